// *** inc/uart_frame_cfg.svh ***
`ifndef UART_FRAME_CFG_SVH
`define UART_FRAME_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UFC_OFF_CTRL_ONE 8'h00
`define UFC_OFF_CTRL_TWO 8'h04
`define UFC_OFF_TX_DATA 8'h08
`define UFC_OFF_RX_DATA 8'h0C
`define UFC_OFF_STATUS 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UFC_C2_TX_ON 0
`define UFC_C2_RX_ON 1
`define UFC_C2_DIR 2
`define UFC_C2_STANDBY 3
`define UFC_ST_RX_FULL 0
`define UFC_ST_PARITY_ERR 1
`define UFC_ST_FRAME_ERR 2
`define UFC_ST_OVERRUN 3
`define UFC_ST_IDLE 4
`define UFC_ST_TX_BUSY 5

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define UFC_CTRL_ONE_RST 8'h00
`define UFC_BIT_CYCLES 16
`define UFC_IDLE_BITS_8 10
`define UFC_IDLE_BITS_9 11

`endif

// *** inc/uart_frame_pkg.sv ***
package uart_frame_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic echo_path_select;
    logic halt_in_wait;
    logic receive_source_select;
    logic char_nine;
    logic wake_on_mark;
    logic idle_count_type;
    logic parity_on;
    logic parity_odd_select;
  } ctrl_one_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
  } bus_req_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_START = 2'b01,
    S_DATA = 2'b11,
    S_STOP = 2'b10
  } ser_state_t;

endpackage : uart_frame_pkg

// *** rtl/pin_sync2.sv ***
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // Idle line level is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      q <= '1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : pin_sync2

// *** rtl/uart_frame_loop_config.sv ***
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "uart_frame_cfg.svh"
module uart_frame_loop_config
  import uart_frame_pkg::*;
#(
  parameter int BIT_CYCLES = `UFC_BIT_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CPU power state
  input wire logic cpu_wait,
  // Serial pins
  input wire logic rxd_in,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic rxd_owned,
  output logic unit_clk_run
);
  localparam logic [15:0] BITC = 16'(BIT_CYCLES);
  localparam logic [15:0] HALFC = 16'(BIT_CYCLES / 2);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic par_of(input logic [8:0] d, input logic nine);
    par_of = nine ? ^d : ^d[7:0];
  endfunction : par_of

  function automatic logic [15:0] idle_limit(input logic nine);
    idle_limit = nine ? 16'(BIT_CYCLES * `UFC_IDLE_BITS_9) :
                        16'(BIT_CYCLES * `UFC_IDLE_BITS_8);
  endfunction : idle_limit

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_sync;
  pin_sync2 #(.WIDTH(2)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({rxd_in, txd_in}),
    .q(pin_sync)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctrl_one_t ctrl_one_reg;
  bus_req_t req_reg;
  logic tx_on_reg, rx_on_reg, dir_reg, standby_reg;
  logic rx_full_reg, parity_err_reg, frame_err_reg, overrun_reg, idle_reg;
  logic [8:0] rx_data_reg, tx_hold_reg, tx_shift_reg, rx_shift_reg;
  logic tx_pend_reg, idle_armed_reg;
  ser_state_t tx_state_reg, rx_state_reg;
  logic [15:0] tx_cnt_reg, rx_cnt_reg, idle_cnt_reg;
  logic [3:0] tx_bit_reg, rx_bit_reg;
  logic take, wr_en, rd_rx, freeze, tx_load, rx_done, idle_hit, rx_src;
  logic [3:0] last_bit;
  logic [8:0] rx_char;
  logic rx_msb, rx_perr, rx_accept, mark_wake;
  logic [31:0] rd_mux;
  logic [7:0] st_clr;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign take = hsel & htrans[1] & hready;
  assign wr_en = req_reg.valid & req_reg.wr;
  assign rd_rx = take & ~hwrite & (haddr[7:0] == `UFC_OFF_RX_DATA);
  assign st_clr = (wr_en && req_reg.addr == `UFC_OFF_STATUS) ? hwdata[7:0] : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
    end else begin
      req_reg.valid <= take;
      req_reg.wr <= hwrite;
      req_reg.addr <= haddr[7:0];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == `UFC_OFF_CTRL_ONE) begin
      rd_mux[7:0] = ctrl_one_reg;
    end else if (haddr[7:0] == `UFC_OFF_CTRL_TWO) begin
      rd_mux[`UFC_C2_TX_ON] = tx_on_reg;
      rd_mux[`UFC_C2_RX_ON] = rx_on_reg;
      rd_mux[`UFC_C2_DIR] = dir_reg;
      rd_mux[`UFC_C2_STANDBY] = standby_reg;
    end else if (haddr[7:0] == `UFC_OFF_TX_DATA) begin
      rd_mux[8:0] = tx_hold_reg;
    end else if (haddr[7:0] == `UFC_OFF_RX_DATA) begin
      rd_mux[8:0] = rx_data_reg;
    end else if (haddr[7:0] == `UFC_OFF_STATUS) begin
      rd_mux[`UFC_ST_RX_FULL] = rx_full_reg;
      rd_mux[`UFC_ST_PARITY_ERR] = parity_err_reg;
      rd_mux[`UFC_ST_FRAME_ERR] = frame_err_reg;
      rd_mux[`UFC_ST_OVERRUN] = overrun_reg;
      rd_mux[`UFC_ST_IDLE] = idle_reg;
      rd_mux[`UFC_ST_TX_BUSY] = tx_pend_reg | (tx_state_reg != S_IDLE);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hrdata <= (take && !hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_one_reg <= `UFC_CTRL_ONE_RST;
      tx_on_reg <= 1'b0;
      rx_on_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else if (wr_en && req_reg.addr == `UFC_OFF_CTRL_ONE) begin
      ctrl_one_reg <= hwdata[7:0];
    end else if (wr_en && req_reg.addr == `UFC_OFF_CTRL_TWO) begin
      tx_on_reg <= hwdata[`UFC_C2_TX_ON];
      rx_on_reg <= hwdata[`UFC_C2_RX_ON];
      dir_reg <= hwdata[`UFC_C2_DIR];
    end
  end

  // Software write of standby wins over a wake in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      standby_reg <= 1'b0;
    end else if (wr_en && req_reg.addr == `UFC_OFF_CTRL_TWO) begin
      standby_reg <= hwdata[`UFC_C2_STANDBY];
    end else if (mark_wake || (idle_hit && !ctrl_one_reg.wake_on_mark)) begin
      standby_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin routing and wait mode
  // ----------------------------------------------------------------
  assign freeze = ctrl_one_reg.halt_in_wait & cpu_wait;

  always_comb begin
    if (!ctrl_one_reg.echo_path_select) begin
      rx_src = pin_sync[1];
    end else if (ctrl_one_reg.receive_source_select) begin
      rx_src = pin_sync[0];
    end else begin
      rx_src = txd_out;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_oe <= 1'b0;
      rxd_owned <= 1'b0;
      unit_clk_run <= 1'b1;
    end else begin
      if (ctrl_one_reg.echo_path_select && ctrl_one_reg.receive_source_select) begin
        txd_oe <= tx_on_reg & dir_reg;
      end else begin
        txd_oe <= tx_on_reg;
      end
      rxd_owned <= rx_on_reg & ~ctrl_one_reg.echo_path_select;
      unit_clk_run <= ~freeze;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign last_bit = ctrl_one_reg.char_nine ? 4'd8 : 4'd7;
  assign tx_load = (tx_state_reg == S_IDLE) & tx_pend_reg & tx_on_reg & ~freeze;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_hold_reg <= 9'h000;
      tx_pend_reg <= 1'b0;
    end else if (wr_en && req_reg.addr == `UFC_OFF_TX_DATA && !tx_pend_reg) begin
      tx_hold_reg <= hwdata[8:0];
      tx_pend_reg <= 1'b1;
    end else if (tx_load) begin
      tx_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= S_IDLE;
      tx_shift_reg <= 9'h000;
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
      txd_out <= 1'b1;
    end else if (!freeze) begin
      case (tx_state_reg)
        S_IDLE: begin
          txd_out <= 1'b1;
          if (tx_load) begin
            tx_shift_reg <= tx_hold_reg;
            if (ctrl_one_reg.parity_on && ctrl_one_reg.char_nine) begin
              tx_shift_reg[8] <= par_of({1'b0, tx_hold_reg[7:0]}, 1'b1) ^
                                 ctrl_one_reg.parity_odd_select;
            end else if (ctrl_one_reg.parity_on) begin
              tx_shift_reg[7] <= ^tx_hold_reg[6:0] ^ ctrl_one_reg.parity_odd_select;
            end
            tx_cnt_reg <= BITC;
            tx_state_reg <= S_START;
            txd_out <= 1'b0;
          end
        end
        S_START: begin
          if (tx_cnt_reg == 16'h0001) begin
            tx_cnt_reg <= BITC;
            tx_bit_reg <= 4'h0;
            txd_out <= tx_shift_reg[0];
            tx_state_reg <= S_DATA;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
        S_DATA: begin
          if (tx_cnt_reg != 16'h0001) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end else if (tx_bit_reg == last_bit) begin
            tx_cnt_reg <= BITC;
            txd_out <= 1'b1;
            tx_state_reg <= S_STOP;
          end else begin
            tx_cnt_reg <= BITC;
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            txd_out <= tx_shift_reg[1];
            tx_bit_reg <= tx_bit_reg + 4'h1;
          end
        end
        default: begin
          if (tx_cnt_reg == 16'h0001) begin
            tx_state_reg <= S_IDLE;
          end else begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  assign rx_done = ~freeze & (rx_state_reg == S_STOP) & (rx_cnt_reg == 16'h0001);
  assign rx_char = ctrl_one_reg.char_nine ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
  assign rx_msb = ctrl_one_reg.char_nine ? rx_char[8] : rx_char[7];
  assign rx_perr = ctrl_one_reg.parity_on &
                   (par_of(rx_char, ctrl_one_reg.char_nine) !=
                    ctrl_one_reg.parity_odd_select);
  assign mark_wake = rx_done & standby_reg & ctrl_one_reg.wake_on_mark & rx_msb;
  assign rx_accept = rx_done & (~standby_reg | mark_wake);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg <= S_IDLE;
      rx_shift_reg <= 9'h000;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
    end else if (!rx_on_reg) begin
      rx_state_reg <= S_IDLE;
    end else if (!freeze) begin
      case (rx_state_reg)
        S_IDLE: begin
          if (!rx_src) begin
            rx_cnt_reg <= HALFC;
            rx_state_reg <= S_START;
          end
        end
        S_START: begin
          if (rx_cnt_reg != 16'h0001) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end else if (!rx_src) begin
            rx_cnt_reg <= BITC;
            rx_bit_reg <= 4'h0;
            rx_state_reg <= S_DATA;
          end else begin
            rx_state_reg <= S_IDLE;
          end
        end
        S_DATA: begin
          if (rx_cnt_reg != 16'h0001) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end else begin
            rx_cnt_reg <= BITC;
            rx_shift_reg <= {rx_src, rx_shift_reg[8:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == last_bit) begin
              rx_state_reg <= S_STOP;
            end
          end
        end
        default: begin
          if (rx_cnt_reg == 16'h0001) begin
            rx_state_reg <= S_IDLE;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // Flags: hardware set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data_reg <= 9'h000;
      rx_full_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      frame_err_reg <= 1'b0;
      overrun_reg <= 1'b0;
      idle_reg <= 1'b0;
    end else begin
      if (rx_accept && !rx_full_reg) begin
        rx_data_reg <= rx_char;
      end
      rx_full_reg <= rx_accept | (rx_full_reg & ~rd_rx & ~st_clr[`UFC_ST_RX_FULL]);
      parity_err_reg <= (rx_accept & rx_perr) |
                        (parity_err_reg & ~st_clr[`UFC_ST_PARITY_ERR]);
      frame_err_reg <= (rx_accept & ~rx_src) | (frame_err_reg & ~st_clr[`UFC_ST_FRAME_ERR]);
      overrun_reg <= (rx_accept & rx_full_reg) | (overrun_reg & ~st_clr[`UFC_ST_OVERRUN]);
      idle_reg <= idle_hit | (idle_reg & ~st_clr[`UFC_ST_IDLE]);
    end
  end

  // ----------------------------------------------------------------
  // Idle line detection
  // ----------------------------------------------------------------
  assign idle_hit = ~freeze & idle_armed_reg &
                    (idle_cnt_reg == idle_limit(ctrl_one_reg.char_nine) - 16'h0001) & rx_src;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_reg <= 16'h0000;
      idle_armed_reg <= 1'b0;
    end else if (!rx_on_reg) begin
      idle_cnt_reg <= 16'h0000;
      idle_armed_reg <= 1'b0;
    end else if (!freeze) begin
      if (!rx_src || (ctrl_one_reg.idle_count_type && rx_state_reg != S_IDLE)) begin
        idle_cnt_reg <= 16'h0000;
      end else if (idle_cnt_reg != idle_limit(ctrl_one_reg.char_nine)) begin
        idle_cnt_reg <= idle_cnt_reg + 16'h0001;
      end
      if (rx_state_reg == S_DATA) begin
        idle_armed_reg <= 1'b1;
      end else if (idle_hit) begin
        idle_armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_normal_route: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_one_reg.echo_path_select |-> rx_src == $past(rxd_in, 2))
    else $error("receiver not on receive pin in normal mode");
  chk_loop_internal: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_one_reg.echo_path_select && !ctrl_one_reg.receive_source_select |-> rx_src == txd_out)
    else $error("loopback not fed from transmitter");
  chk_single_wire: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_one_reg.echo_path_select && ctrl_one_reg.receive_source_select
    |-> rx_src == $past(txd_in, 2))
    else $error("single wire receiver not on transmit pin");
  chk_pin_release: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_one_reg.echo_path_select |=> !rxd_owned)
    else $error("receive pin held in loop mode");
  chk_wire_direction: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_one_reg.echo_path_select && ctrl_one_reg.receive_source_select && !dir_reg
    |=> !txd_oe)
    else $error("shared pin driven while set as input");
  chk_wait_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
    freeze && tx_state_reg != S_IDLE |=> $stable(tx_cnt_reg) && $stable(tx_state_reg))
    else $error("transmitter moved while frozen");
  chk_start_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_load |=> !txd_out ##1 (!txd_out || freeze))
    else $error("start bit missing");
  chk_frame_len: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_state_reg == S_DATA |-> tx_bit_reg <= last_bit)
    else $error("too many data bits");
  chk_tx_parity: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_load && ctrl_one_reg.parity_on && !$changed(ctrl_one_reg)
    |=> par_of(tx_shift_reg, ctrl_one_reg.char_nine) == ctrl_one_reg.parity_odd_select)
    else $error("generated parity wrong");
  chk_parity_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_accept && rx_perr |=> parity_err_reg)
    else $error("parity error not flagged");
  chk_idle_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    idle_hit && standby_reg && !ctrl_one_reg.wake_on_mark && !wr_en |=> !standby_reg)
    else $error("idle line did not wake receiver");
  chk_idle_type: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_on_reg && ctrl_one_reg.idle_count_type && rx_state_reg != S_IDLE && !freeze
    |=> idle_cnt_reg == 16'h0000)
    else $error("idle count ran inside a character");
endmodule : uart_frame_loop_config

// *** tb/uart_remote_node.sv ***
`timescale 1ns/1ps
module uart_remote_node #(
  parameter int BIT_CYCLES = 4
) (
  // Clock
  input wire logic hclk,
  // Line levels
  output logic rx_line,
  output logic sw_en,
  output logic sw_val
);
  initial begin
    rx_line = 1'b1;
    sw_en = 1'b0;
    sw_val = 1'b1;
  end

  // --------------------------------------------------------------
  // Character sender, on the receive pin or the shared pin
  // --------------------------------------------------------------
  task automatic send(input logic [8:0] d, input int nb, input bit sw);
    logic [10:0] fr;
    fr = 11'h7ff;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++) begin
      fr[i+1] = d[i];
    end
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge hclk);
      sw_en <= sw;
      sw_val <= fr[i];
      if (!sw) begin
        rx_line <= fr[i];
      end
      repeat (BIT_CYCLES - 1) @(posedge hclk);
    end
    // Released pin returns to its pull-up level
    @(posedge hclk);
    sw_en <= 1'b0;
  endtask : send
endmodule : uart_remote_node

// *** tb/uart_frame_loop_config_tb_top.sv ***
`timescale 1ns/1ps
module uart_frame_loop_config_tb_top;
  localparam int BC = 4;
  logic hclk, hresetn, hsel, hwrite, cpu_wait;
  logic [31:0] haddr, hwdata, hrdata, v, st;
  logic [1:0] htrans;
  logic hreadyout, hresp, txd_out, txd_oe, rxd_owned, unit_clk_run;
  logic rx_line, sw_en, sw_val, txd_in;
  logic [8:0] f;
  int bad_count, num_checks;
  logic [7:0] tc1 [6] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h12, 8'h13};
  logic [8:0] ttx [6] = '{9'h05a, 9'h07f, 9'h07f, 9'h1a5, 9'h103, 9'h0ff};
  logic [8:0] tex [6] = '{9'h05a, 9'h0ff, 9'h07f, 9'h1a5, 9'h003, 9'h1ff};
  int tnb [6] = '{8, 8, 8, 9, 9, 9};

  uart_frame_loop_config #(.BIT_CYCLES(BC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_wait(cpu_wait),
    .rxd_in(rx_line), .txd_in(txd_in), .txd_out(txd_out), .txd_oe(txd_oe),
    .rxd_owned(rxd_owned), .unit_clk_run(unit_clk_run)
  );
  uart_remote_node #(.BIT_CYCLES(BC)) P (
    .hclk(hclk), .rx_line(rx_line), .sw_en(sw_en), .sw_val(sw_val)
  );
  // Shared transmit pin, pulled up when nobody drives
  assign txd_in = txd_oe ? txd_out : (sw_en ? sw_val : 1'b1);

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // --------------------------------------------------------------
  // Report, compare and bus tasks
  // --------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
      bad_count++;
    end
  endtask : chk1

  // Values are taken at the negedge before the sampling edge
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    logic r;
    n = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      chk1("hresp_okay", 1'b0, hresp);
      @(posedge hclk);
      n++;
    end while (r !== 1'b1 && n < 100);
    if (r !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic [31:0] x;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy(x);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(nm, e, x);
  endtask : rchk

  // Polls receive-full, then reads the character
  task automatic rxg(output logic [31:0] s, output logic [31:0] d);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h10, 32'h0000_0000, s);
      n++;
    end while (s[0] !== 1'b1 && n < 60);
    chk1("rx_full", 1'b1, s[0]);
    bus(1'b0, 8'h0c, 32'h0000_0000, d);
  endtask : rxg

  // Captures one transmitted frame at mid-bit
  task automatic cap(input int nb, output logic [8:0] d);
    int n;
    n = 0;
    d = 9'h000;
    do begin
      @(negedge hclk);
      n++;
    end while (txd_out !== 1'b0 && n < 500);
    if (n >= 500) begin
      bad_count++;
      summarize();
    end
    repeat (BC / 2) @(negedge hclk);
    chk1("start_bit", 1'b0, txd_out);
    for (int i = 0; i < nb; i++) begin
      repeat (BC) @(negedge hclk);
      d[i] = txd_out;
    end
    repeat (BC) @(negedge hclk);
    chk1("stop_bit", 1'b1, txd_out);
  endtask : cap

  task automatic pins(input string nm, input logic [2:0] e);
    repeat (2) @(negedge hclk);
    chk(nm, {29'h0, e}, {29'h0, txd_oe, rxd_owned, unit_clk_run});
  endtask : pins

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    cpu_wait = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (5) @(posedge hclk);
    chk("reset_pins", 32'h0000_0001, {29'h0, txd_oe, rxd_owned, unit_clk_run});
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rchk("ctrl_one_reset", 8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_00a5);
    rchk("ctrl_one_rw", 8'h00, 32'h0000_00a5);
    rchk("unmapped", 8'h14, 32'h0000_0000);
    @(posedge hclk);
    cpu_wait <= 1'b1;
    pins("wait_run", 3'b001);
    wr(8'h00, 32'h0000_0040);
    pins("wait_halt", 3'b000);
    @(posedge hclk);
    cpu_wait <= 1'b0;
    pins("wait_left", 3'b001);
    wr(8'h04, 32'h0000_0003);
    wr(8'h00, 32'h0000_0000);
    pins("normal_pins", 3'b111);
    P.send(9'h05a, 8, 1'b0);
    rxg(st, v);
    chk("rx_pin", 32'h0000_005a, v);
    wr(8'h00, 32'h0000_0020);
    pins("src_no_loop", 3'b111);
    P.send(9'h0c3, 8, 1'b0);
    rxg(st, v);
    chk("rx_src_no_loop", 32'h0000_00c3, v);
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, {24'h00_0000, tc1[i]});
      wr(8'h08, {23'h0, ttx[i]});
      cap(tnb[i], f);
      chk("tx_frame", {23'h0, tex[i]}, {23'h0, f});
    end
    // Freeze a character in its start bit, then let it finish
    wr(8'h00, 32'h0000_0040);
    wr(8'h08, 32'h0000_00c5);
    @(posedge hclk);
    cpu_wait <= 1'b1;
    repeat (20) @(negedge hclk);
    chk1("frozen_line", 1'b0, txd_out);
    chk1("frozen_clk", 1'b0, unit_clk_run);
    @(posedge hclk);
    cpu_wait <= 1'b0;
    cap(8, f);
    chk("tx_frozen", 32'h0000_00c5, {23'h0, f});
    wr(8'h00, 32'h0000_0080);
    pins("loop_pins", 3'b101);
    fork
      P.send(9'h011, 8, 1'b0);
    join_none
    wr(8'h08, 32'h0000_003c);
    cap(8, f);
    chk("tx_loop", 32'h0000_003c, {23'h0, f});
    rxg(st, v);
    chk("rx_loopback", 32'h0000_003c, v);
    wr(8'h00, 32'h0000_00a0);
    wr(8'h04, 32'h0000_0007);
    pins("sw_drive", 3'b101);
    wr(8'h08, 32'h0000_0066);
    cap(8, f);
    chk("tx_sw_own", 32'h0000_0066, {23'h0, f});
    rxg(st, v);
    chk("rx_sw_own", 32'h0000_0066, v);
    wr(8'h04, 32'h0000_0003);
    pins("sw_listen", 3'b001);
    P.send(9'h099, 8, 1'b1);
    rxg(st, v);
    chk("rx_sw_pin", 32'h0000_0099, v);
    wr(8'h00, 32'h0000_0002);
    wr(8'h10, 32'h0000_001f);
    P.send(9'h081, 8, 1'b0);
    rxg(st, v);
    chk1("parity_ok", 1'b0, st[1]);
    chk("rx_parity", 32'h0000_0081, v);
    P.send(9'h001, 8, 1'b0);
    rxg(st, v);
    chk1("parity_err", 1'b1, st[1]);
    chk1("idle_early", 1'b0, st[4]);
    repeat (12 * BC) @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0000_0000, st);
    chk1("idle_flag", 1'b1, st[4]);
    // Nine-bit receive with odd parity
    wr(8'h00, 32'h0000_0013);
    wr(8'h10, 32'h0000_001f);
    P.send(9'h17e, 9, 1'b0);
    rxg(st, v);
    chk("rx_nine", 32'h0000_017e, v);
    chk1("parity_nine", 1'b0, st[1]);
    // Idle count after stop bit wakes a receiver in standby
    wr(8'h00, 32'h0000_0004);
    wr(8'h10, 32'h0000_001f);
    wr(8'h04, 32'h0000_000b);
    P.send(9'h0ff, 8, 1'b0);
    repeat (8) @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0000_0000, st);
    chk1("idle_after_stop", 1'b0, st[4]);
    rchk("standby_held", 8'h04, 32'h0000_000b);
    repeat (40) @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0000_0000, st);
    chk1("idle_stop_flag", 1'b1, st[4]);
    chk1("rx_discard", 1'b0, st[0]);
    rchk("idle_wake", 8'h04, 32'h0000_0003);
    wr(8'h00, 32'h0000_0008);
    wr(8'h04, 32'h0000_000b);
    P.send(9'h005, 8, 1'b0);
    bus(1'b0, 8'h10, 32'h0000_0000, st);
    chk1("standby_drop", 1'b0, st[0]);
    P.send(9'h085, 8, 1'b0);
    rxg(st, v);
    chk("mark_wake", 32'h0000_0085, v);
    summarize();
  end
endmodule : uart_frame_loop_config_tb_top
